// ---- pkg/xcv_map.svh ----
// offsets, field positions, reset values and timing counts of the control bank
// assumes inclusion by bare name from the package and the design files
`ifndef XCV_MAP_SVH
`define XCV_MAP_SVH

// register addresses on the two-wire interface
`define XCV_LOOPBACK_SELECT_ADDR 8'h02
`define XCV_DIAG_CONVERTER_CONTROL_ADDR 8'h03
`define XCV_RECEIVE_PATH_CONTROL_ADDR 8'h04
`define XCV_RECEIVE_EQUALIZER_LOSS_CONTROL_ADDR 8'h05
`define XCV_RECEIVE_THRESHOLD_HYSTERESIS_ADDR 8'h06
`define XCV_RECEIVE_LOSS_LEVEL_ADDR 8'h07
`define XCV_FIRST_INDEX 2
`define XCV_LAST_INDEX 7

// reset value shared by every register
`define XCV_REG_RESET 8'h00
`define XCV_READ_UNMAPPED 8'h00

// loopback_select fields
`define XCV_RX_LOOP_SELECT_BIT 1
`define XCV_TX_LOOP_SELECT_BIT 0

// diag_converter_control fields
`define XCV_DIAG_CONV_ON_BIT 7
`define XCV_DIAG_OSC_ON_BIT 6
`define XCV_DIAG_CONV_HOLD_BIT 4
`define XCV_DIAG_INPUT_PICK_MSB 2
`define XCV_DIAG_INPUT_PICK_LSB 0

// receive_path_control fields
`define XCV_RX_POWER_DOWN_BIT 7
`define XCV_RX_DRIVER_OFF_BIT 6
`define XCV_RX_INVERT_BIT 5
`define XCV_RX_RECOVERY_OFF_BIT 4
`define XCV_RX_RECOVERY_SKIP_BIT 3
`define XCV_RX_OFFSET_CANCEL_OFF_BIT 2
`define XCV_RX_EQUALIZER_OFF_BIT 1
`define XCV_RX_LOSS_RANGE_BIT 0

// receive_equalizer_loss_control fields
`define XCV_RX_FAST_LOSS_BIT 3
`define XCV_RX_LINEAR_EQ_MSB 2
`define XCV_RX_LINEAR_EQ_LSB 0

// receive_threshold_hysteresis fields
`define XCV_RX_HYSTERESIS_CUT_BIT 7
`define XCV_RX_CROSSPOINT_SIGN_BIT 4
`define XCV_RX_CROSSPOINT_MAG_MSB 3
`define XCV_RX_CROSSPOINT_MAG_LSB 0

// serial framing
`define XCV_BITS_PER_BYTE 4'h8
`define XCV_SLAVE_ADDR_DEFAULT 7'h2a

`endif

// ---- pkg/xcv_pkg.sv ----
// types of the transceiver control bank
// assumes xcv_map.svh on the include path
package xcv_pkg;
  `include "xcv_map.svh"

  typedef logic [7:0] xcv_byte_t;

  // gray codes along idle, address, ack, register, ack, data, ack
  typedef enum logic [3:0] {
    XCV_ST_IDLE = 4'h0,
    XCV_ST_DEV = 4'h1,
    XCV_ST_DEV_ACK = 4'h3,
    XCV_ST_REG = 4'h2,
    XCV_ST_REG_ACK = 4'h6,
    XCV_ST_WR = 4'h7,
    XCV_ST_WR_ACK = 4'h5,
    XCV_ST_SKIP = 4'h4,
    XCV_ST_RD = 4'hc,
    XCV_ST_RD_ACK = 4'hd
  } xcv_state_t;
endpackage : xcv_pkg

// ---- pkg/xcv_pin_if.sv ----
// filtered two-wire pin levels passed from the pin filters to the slave logic
// assumes one clock domain, the filters produce the levels
interface xcv_pin_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface : xcv_pin_if

// ---- verilog/xcv_pin_filter.sv ----
// three-stage pin synchroniser with agreement filter
// assumes an asynchronous pin input and an active high asynchronous reset
module xcv_pin_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
    end else if (s2_q == s3_q) begin
      level <= s3_q;
    end
  end
endmodule : xcv_pin_filter

// ---- verilog/xcv_rx_ctrl_regs.sv ----
// two-wire slave and control registers of the transceiver core and receive path
// assumes open-drain pins resolved outside, TX_RECOVERY_SKIP from the transmit bank
`include "xcv_map.svh"
// Summary of operation
// - bit1 reg2: receive path takes transmit recovery
// - bit0 reg2: transmit path takes receive recovery
// - bit7 reg3 enables diagnostic converter
// - bit6 reg3 runs converter oscillator
// - bit4 reg3 holds converter in reset
// - bits2:0 reg3 pick converter input
// - bit7 reg4 powers down receive path
// - bit6 reg4 disables receive output driver
// - bit5 reg4 inverts receive output polarity
// - bit4 reg4 disables and bypasses receive recovery
// - receive skip needs transmit skip too
// - bit2 reg4 disables offset cancel, threshold
// - bit1 reg4 disables and bypasses equalizer
// - bit0 reg4 picks low loss range
// - bit3 reg5 selects fast loss detection
// - bits2:0 reg5 set linear equalizer strength
// - bit7 reg6 lowers hysteresis about 2dB
// - reg6 crosspoint sign bit4, magnitude 3:0
module xcv_rx_ctrl_regs
  import xcv_pkg::*;
#(
  // arbitrary neutral value
  parameter logic [6:0] SLAVE_ADDR = `XCV_SLAVE_ADDR_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic TX_RECOVERY_SKIP,
  output logic RX_LOOP_SELECT,
  output logic TX_LOOP_SELECT,
  output logic DIAG_CONV_ON,
  output logic DIAG_OSC_ON,
  output logic DIAG_CONV_HOLD,
  output logic [2:0] DIAG_INPUT_PICK,
  output logic RX_POWER_DOWN,
  output logic RX_DRIVER_OFF,
  output logic RX_INVERT,
  output logic RX_RECOVERY_OFF,
  output logic RX_RECOVERY_SKIP,
  output logic RX_OFFSET_CANCEL_OFF,
  output logic RX_EQUALIZER_OFF,
  output logic RX_LOSS_RANGE,
  output logic RX_FAST_LOSS,
  output logic [2:0] RX_LINEAR_EQ_LEVEL,
  output logic RX_HYSTERESIS_CUT,
  output logic RX_CROSSPOINT_SIGN,
  output logic [3:0] RX_CROSSPOINT_MAGNITUDE
);

  xcv_pin_if pins ();

  xcv_pin_filter u_scl_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .pin(SCL_IN),
    .level(pins.scl)
  );

  xcv_pin_filter u_sda_filter (
    .clk(SYS_CLK),
    .rst(RST),
    .pin(SDA_IN),
    .level(pins.sda)
  );

  xcv_state_t state_q;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] bit_q;
  xcv_byte_t shift_q;
  xcv_byte_t addr_q;
  xcv_byte_t rd_q;
  xcv_byte_t regs_q [`XCV_FIRST_INDEX:`XCV_LAST_INDEX];
  logic wr_en;
  logic addr_hit;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic dev_match;
  xcv_byte_t rd_data;

  // previous filtered levels for edge and condition detection
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= pins.scl;
      sda_p_q <= pins.sda;
    end
  end

  assign scl_rise = pins.scl & ~scl_p_q;
  assign scl_fall = ~pins.scl & scl_p_q;
  assign start_seen = pins.scl & scl_p_q & sda_p_q & ~pins.sda;
  assign stop_seen = pins.scl & scl_p_q & ~sda_p_q & pins.sda;
  assign byte_done = (bit_q == `XCV_BITS_PER_BYTE);
  assign dev_match = (shift_q[7:1] == SLAVE_ADDR);

  // register address decode; unmapped addresses are acked but inert
  assign addr_hit = (addr_q >= `XCV_LOOPBACK_SELECT_ADDR) &&
                    (addr_q <= `XCV_RECEIVE_LOSS_LEVEL_ADDR);

  // full address decode, so no index ever leaves the register range
  always_comb begin
    case (addr_q)
      `XCV_LOOPBACK_SELECT_ADDR: begin
        rd_data = regs_q[2];
      end
      `XCV_DIAG_CONVERTER_CONTROL_ADDR: begin
        rd_data = regs_q[3];
      end
      `XCV_RECEIVE_PATH_CONTROL_ADDR: begin
        rd_data = regs_q[4];
      end
      `XCV_RECEIVE_EQUALIZER_LOSS_CONTROL_ADDR: begin
        rd_data = regs_q[5];
      end
      `XCV_RECEIVE_THRESHOLD_HYSTERESIS_ADDR: begin
        rd_data = regs_q[6];
      end
      `XCV_RECEIVE_LOSS_LEVEL_ADDR: begin
        rd_data = regs_q[7];
      end
      default: begin
        rd_data = `XCV_READ_UNMAPPED;
      end
    endcase
  end

  // frame sequencer: device address, register address, one data byte
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= XCV_ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (start_seen) begin
      state_q <= XCV_ST_DEV;
      bit_q <= 4'h0;
    end else if (stop_seen) begin
      state_q <= XCV_ST_IDLE;
      bit_q <= 4'h0;
    end else begin
      case (state_q)
        XCV_ST_IDLE: begin
          bit_q <= 4'h0;
        end
        XCV_ST_DEV, XCV_ST_REG, XCV_ST_WR: begin
          if (scl_rise && !byte_done) begin
            shift_q <= {shift_q[6:0], pins.sda};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_q <= 4'h0;
            if (state_q == XCV_ST_DEV) begin
              state_q <= dev_match ? XCV_ST_DEV_ACK : XCV_ST_SKIP;
            end else if (state_q == XCV_ST_REG) begin
              state_q <= XCV_ST_REG_ACK;
            end else begin
              state_q <= XCV_ST_WR_ACK;
            end
          end
        end
        XCV_ST_DEV_ACK: begin
          if (scl_fall) begin
            if (shift_q[0]) begin
              state_q <= XCV_ST_RD;
              bit_q <= 4'h1;
            end else begin
              state_q <= XCV_ST_REG;
              bit_q <= 4'h0;
            end
          end
        end
        XCV_ST_REG_ACK: begin
          if (scl_fall) begin
            state_q <= XCV_ST_WR;
            bit_q <= 4'h0;
          end
        end
        XCV_ST_WR_ACK: begin
          // only one data byte per frame; later bytes are not acked
          if (scl_fall) begin
            state_q <= XCV_ST_SKIP;
          end
        end
        XCV_ST_RD: begin
          if (scl_fall) begin
            if (byte_done) begin
              state_q <= XCV_ST_RD_ACK;
              bit_q <= 4'h0;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        XCV_ST_RD_ACK: begin
          if (scl_fall) begin
            state_q <= XCV_ST_SKIP;
          end
        end
        XCV_ST_SKIP: begin
          bit_q <= 4'h0;
        end
        default: begin
          state_q <= XCV_ST_IDLE;
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // register address latch, taken as the byte after the device address
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      addr_q <= 8'h00;
    end else if (state_q == XCV_ST_REG && scl_fall && byte_done) begin
      addr_q <= shift_q;
    end
  end

  // read shifter: loaded when any matching device address is acked, moves on falling clock
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rd_q <= 8'h00;
    end else if (state_q == XCV_ST_DEV && scl_fall && byte_done && dev_match) begin
      rd_q <= rd_data;
    end else if ((state_q == XCV_ST_DEV_ACK && scl_fall && shift_q[0]) ||
                 (state_q == XCV_ST_RD && scl_fall && !byte_done)) begin
      rd_q <= {rd_q[6:0], 1'b0};
    end
  end

  // open-drain drive: ack slots and read data zeros
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end else if (start_seen || stop_seen) begin
      SDA_OE <= 1'b0;
    end else if (scl_fall) begin
      case (state_q)
        XCV_ST_DEV: begin
          SDA_OE <= byte_done & dev_match;
        end
        XCV_ST_REG, XCV_ST_WR: begin
          SDA_OE <= byte_done;
        end
        XCV_ST_DEV_ACK: begin
          SDA_OE <= shift_q[0] & ~rd_q[7];
        end
        XCV_ST_RD: begin
          SDA_OE <= ~byte_done & ~rd_q[7];
        end
        default: begin
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  assign wr_en = (state_q == XCV_ST_WR) && scl_fall && byte_done && addr_hit;

  // register file: whole byte stored, reserved bits included
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int i = `XCV_FIRST_INDEX; i <= `XCV_LAST_INDEX; i++) begin
        regs_q[i] <= `XCV_REG_RESET;
      end
    end else if (wr_en) begin
      case (addr_q)
        `XCV_LOOPBACK_SELECT_ADDR: begin
          regs_q[2] <= shift_q;
        end
        `XCV_DIAG_CONVERTER_CONTROL_ADDR: begin
          regs_q[3] <= shift_q;
        end
        `XCV_RECEIVE_PATH_CONTROL_ADDR: begin
          regs_q[4] <= shift_q;
        end
        `XCV_RECEIVE_EQUALIZER_LOSS_CONTROL_ADDR: begin
          regs_q[5] <= shift_q;
        end
        `XCV_RECEIVE_THRESHOLD_HYSTERESIS_ADDR: begin
          regs_q[6] <= shift_q;
        end
        `XCV_RECEIVE_LOSS_LEVEL_ADDR: begin
          regs_q[7] <= shift_q;
        end
        default: begin
        end
      endcase
    end
  end

  // effective receive recovery bypass needs the transmit bypass as well
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RX_RECOVERY_SKIP <= 1'b0;
    end else begin
      RX_RECOVERY_SKIP <= regs_q[4][`XCV_RX_RECOVERY_SKIP_BIT] & TX_RECOVERY_SKIP;
    end
  end

  // loopback path selection
  assign RX_LOOP_SELECT = regs_q[2][`XCV_RX_LOOP_SELECT_BIT];
  assign TX_LOOP_SELECT = regs_q[2][`XCV_TX_LOOP_SELECT_BIT];

  // diagnostic converter control
  assign DIAG_CONV_ON = regs_q[3][`XCV_DIAG_CONV_ON_BIT];
  assign DIAG_OSC_ON = regs_q[3][`XCV_DIAG_OSC_ON_BIT];
  assign DIAG_CONV_HOLD = regs_q[3][`XCV_DIAG_CONV_HOLD_BIT];
  assign DIAG_INPUT_PICK =
    regs_q[3][`XCV_DIAG_INPUT_PICK_MSB:`XCV_DIAG_INPUT_PICK_LSB];

  // receive path control
  assign RX_POWER_DOWN = regs_q[4][`XCV_RX_POWER_DOWN_BIT];
  assign RX_DRIVER_OFF = regs_q[4][`XCV_RX_DRIVER_OFF_BIT];
  assign RX_INVERT = regs_q[4][`XCV_RX_INVERT_BIT];
  assign RX_RECOVERY_OFF = regs_q[4][`XCV_RX_RECOVERY_OFF_BIT];
  assign RX_OFFSET_CANCEL_OFF = regs_q[4][`XCV_RX_OFFSET_CANCEL_OFF_BIT];
  assign RX_EQUALIZER_OFF = regs_q[4][`XCV_RX_EQUALIZER_OFF_BIT];
  assign RX_LOSS_RANGE = regs_q[4][`XCV_RX_LOSS_RANGE_BIT];

  // equalizer and loss detection
  assign RX_FAST_LOSS = regs_q[5][`XCV_RX_FAST_LOSS_BIT];
  assign RX_LINEAR_EQ_LEVEL =
    regs_q[5][`XCV_RX_LINEAR_EQ_MSB:`XCV_RX_LINEAR_EQ_LSB];

  // threshold and hysteresis
  assign RX_HYSTERESIS_CUT = regs_q[6][`XCV_RX_HYSTERESIS_CUT_BIT];
  assign RX_CROSSPOINT_SIGN = regs_q[6][`XCV_RX_CROSSPOINT_SIGN_BIT];
  assign RX_CROSSPOINT_MAGNITUDE =
    regs_q[6][`XCV_RX_CROSSPOINT_MAG_MSB:`XCV_RX_CROSSPOINT_MAG_LSB];

endmodule : xcv_rx_ctrl_regs

// ---- tb/xcv_host_model.sv ----
// two-wire bus master standing in for the host controller
// assumes the bench resolves the data wire with a pull-up
`include "xcv_map.svh"
module xcv_host_model
  import xcv_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] result;
  event done;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // drives one bit, 1 releases, and samples mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
    tick(5);
  endtask : bit_io
  task automatic byte_io(input xcv_byte_t v, output xcv_byte_t r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io
  task automatic start_cond();
    sda_low = 1'b0;
    tick(8);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(5);
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_low = 1'b0;
    tick(10);
  endtask : stop_cond
  task automatic write_reg(input xcv_byte_t a, input xcv_byte_t d, input logic [6:0] dev);
    xcv_byte_t r;
    start_cond();
    byte_io({dev, 1'b0}, r, result[10]);
    byte_io(a, r, result[9]);
    byte_io(d, r, result[8]);
    stop_cond();
    result[7:0] = 8'h00;
    -> done;
  endtask : write_reg
  task automatic read_reg(input xcv_byte_t a);
    xcv_byte_t r;
    start_cond();
    byte_io({`XCV_SLAVE_ADDR_DEFAULT, 1'b0}, r, result[10]);
    byte_io(a, r, result[9]);
    start_cond();
    byte_io({`XCV_SLAVE_ADDR_DEFAULT, 1'b1}, r, result[8]);
    byte_io(8'hff, result[7:0], r[0]);
    stop_cond();
    -> done;
  endtask : read_reg
endmodule : xcv_host_model

// ---- tb/xcv_rx_ctrl_regs_sva.sv ----
// port checks of the transceiver control bank
// assumes one clock domain and an asynchronous active high reset
module xcv_rx_ctrl_regs_sva (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SCL_IN,
  input wire logic SDA_OE,
  input wire logic TX_RECOVERY_SKIP,
  input wire logic RX_RECOVERY_SKIP,
  input wire logic RX_LOOP_SELECT,
  input wire logic TX_LOOP_SELECT,
  input wire logic DIAG_CONV_ON,
  input wire logic [2:0] DIAG_INPUT_PICK,
  input wire logic RX_POWER_DOWN,
  input wire logic RX_INVERT,
  input wire logic [2:0] RX_LINEAR_EQ_LEVEL,
  input wire logic RX_HYSTERESIS_CUT,
  input wire logic [3:0] RX_CROSSPOINT_MAGNITUDE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  a_skip_needs_tx:
    assert property (RX_RECOVERY_SKIP |-> $past(TX_RECOVERY_SKIP))
    else $error("receive skip without transmit skip");
  a_skip_drops_tx:
    assert property ($fell(TX_RECOVERY_SKIP) |=> !RX_RECOVERY_SKIP)
    else $error("receive skip held after transmit skip fell");
  a_loop_scl_low:
    assert property (!$stable({RX_LOOP_SELECT, TX_LOOP_SELECT}) |-> !SCL_IN && !$past(SCL_IN, 2))
    else $error("loop select changed outside a clock low phase");
  a_diag_scl_low:
    assert property ($changed({DIAG_CONV_ON, DIAG_INPUT_PICK}) |-> !SCL_IN)
    else $error("converter control changed while clock high");
  a_path_scl_low:
    assert property (!$stable({RX_POWER_DOWN, RX_INVERT}) |-> !SCL_IN && !$past(SCL_IN, 3))
    else $error("receive path control changed outside a clock low phase");
  a_eq_scl_low:
    assert property ($changed(RX_LINEAR_EQ_LEVEL) |-> !SCL_IN)
    else $error("equalizer level changed while clock high");
  a_thresh_scl_low:
    assert property ($changed({RX_HYSTERESIS_CUT, RX_CROSSPOINT_MAGNITUDE}) |-> !SCL_IN)
    else $error("threshold control changed while clock high");
  a_drive_after_fall:
    assert property ($rose(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 3))
    else $error("data drive began outside a clock low phase");
  a_drive_steady_high:
    assert property (SCL_IN [*2] |-> $stable(SDA_OE))
    else $error("data drive changed while clock high");
  cover property ($rose(RX_RECOVERY_SKIP));
  cover property ($rose(SDA_OE));
  cover property (DIAG_INPUT_PICK == 3'h7);
endmodule : xcv_rx_ctrl_regs_sva

bind xcv_rx_ctrl_regs xcv_rx_ctrl_regs_sva xcv_rx_ctrl_regs_sva_inst (
  .SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE),
  .TX_RECOVERY_SKIP(TX_RECOVERY_SKIP), .RX_RECOVERY_SKIP(RX_RECOVERY_SKIP),
  .RX_LOOP_SELECT(RX_LOOP_SELECT), .TX_LOOP_SELECT(TX_LOOP_SELECT),
  .DIAG_CONV_ON(DIAG_CONV_ON), .DIAG_INPUT_PICK(DIAG_INPUT_PICK),
  .RX_POWER_DOWN(RX_POWER_DOWN), .RX_INVERT(RX_INVERT),
  .RX_LINEAR_EQ_LEVEL(RX_LINEAR_EQ_LEVEL), .RX_HYSTERESIS_CUT(RX_HYSTERESIS_CUT),
  .RX_CROSSPOINT_MAGNITUDE(RX_CROSSPOINT_MAGNITUDE)
);

// ---- tb/testbench.sv ----
// self-checking bench of the transceiver control bank
// assumes the host model drives the pins and the data wire has a pull-up
`include "xcv_map.svh"
`define XCV_CHK(act, exp) \
  begin \
    total_checks++; \
    if ((act) !== (exp)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, act, exp); \
    end \
  end
module testbench
  import xcv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = `XCV_SLAVE_ADDR_DEFAULT;
  logic sys_clk, rst, tx_skip, scl, sda_low, sda_out, sda_oe;
  wire logic sda = !sda_low && !(sda_oe && !sda_out);
  wire logic [25:0] outs;
  xcv_byte_t regs [2:7];
  logic [10:0] res_q [$];
  logic [25:0] snap_q [$];
  logic [10:0] res_e;
  logic [25:0] snap_e;
  int bad_count = 0;
  int total_checks = 0;
  event snap;
  xcv_rx_ctrl_regs #(.SLAVE_ADDR(DEV)) xcv_rx_ctrl_regs_inst (
    .SYS_CLK(sys_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .TX_RECOVERY_SKIP(tx_skip), .RX_LOOP_SELECT(outs[25]),
    .TX_LOOP_SELECT(outs[24]), .DIAG_CONV_ON(outs[23]), .DIAG_OSC_ON(outs[22]),
    .DIAG_CONV_HOLD(outs[21]), .DIAG_INPUT_PICK(outs[20:18]), .RX_POWER_DOWN(outs[17]),
    .RX_DRIVER_OFF(outs[16]), .RX_INVERT(outs[15]), .RX_RECOVERY_OFF(outs[14]),
    .RX_RECOVERY_SKIP(outs[13]), .RX_OFFSET_CANCEL_OFF(outs[12]),
    .RX_EQUALIZER_OFF(outs[11]), .RX_LOSS_RANGE(outs[10]), .RX_FAST_LOSS(outs[9]),
    .RX_LINEAR_EQ_LEVEL(outs[8:6]), .RX_HYSTERESIS_CUT(outs[5]),
    .RX_CROSSPOINT_SIGN(outs[4]), .RX_CROSSPOINT_MAGNITUDE(outs[3:0])
  );
  xcv_host_model xcv_host_model_inst (
    .clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low)
  );
  function automatic logic [25:0] expect_outs();
    return {regs[2][1:0], regs[3][7:6], regs[3][4], regs[3][2:0], regs[4][7:4],
      regs[4][3] & tx_skip, regs[4][2:0], regs[5][3:0], regs[6][7], regs[6][4:0]};
  endfunction : expect_outs
  task automatic snapshot();
    snap_q.push_back(expect_outs());
    -> snap;
  endtask : snapshot
  task automatic wr(input xcv_byte_t a, input xcv_byte_t d, input logic [6:0] dev);
    res_q.push_back((dev == DEV) ? 11'h000 : 11'h700);
    if (dev == DEV && a >= 8'h02 && a <= 8'h07) begin
      regs[a] = d;
    end
    xcv_host_model_inst.write_reg(a, d, dev);
    snapshot();
  endtask : wr
  task automatic rd(input xcv_byte_t a);
    res_q.push_back({3'b000, (a >= 8'h02 && a <= 8'h07) ? regs[a] : 8'h00});
    xcv_host_model_inst.read_reg(a);
  endtask : rd
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    for (int i = 2; i <= 7; i++) begin
      regs[i] = 8'h00;
    end
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : do_reset
  task automatic print_verdict();
    $display("checks %0d, errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  always @(xcv_host_model_inst.done) begin
    res_e = res_q.pop_front();
    `XCV_CHK(xcv_host_model_inst.result, res_e)
  end
  always @(snap) begin
    snap_e = snap_q.pop_front();
    `XCV_CHK(outs, snap_e)
  end
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #2800000;
    bad_count++;
    print_verdict();
  end
  initial begin
    xcv_byte_t d;
    tx_skip = 1'b0;
    void'($urandom(86));
    do_reset(5);
    for (int a = 2; a <= 7; a++) begin
      rd(8'(a));
    end
    // all ones, all zeros, then random contents
    for (int n = 0; n < 4; n++) begin
      tx_skip = n[0];
      for (int a = 2; a <= 7; a++) begin
        d = (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'($urandom);
        wr(8'(a), d, DEV);
        rd(8'(a));
      end
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h03, {5'($urandom), 3'(c)}, DEV);
    end
    tx_skip = 1'b1;
    wr(8'h04, 8'h08, DEV);
    tx_skip = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    snapshot();
    // unmapped places, then a foreign device address
    wr(8'h08, 8'h5a, DEV);
    rd(8'h08);
    rd(8'h01);
    wr(8'h04, 8'hf7, DEV ^ 7'h01);
    rd(8'h04);
    do_reset(2);
    snapshot();
    rd(8'h04);
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end
endmodule : testbench
